// file: hdl/volatile_config_loader.sv
// volatile configuration loader: fetches flash configuration words at power-on reset,
// holds program-once cells, serves table reads/writes of configuration space.
// assumes flash answers a fetch with a one-cycle valid pulse on the system clock
// and that POR_I and SYS_RST_I come from the synchronous reset sequencer.
// Behaviour
// - programmed bit reads zero, unprogrammed one
// - cells reached only by table access
// - power-on reset copies flash words into cells
// - words at top two program addresses
// - power-on reset forces cells to ones
// - other resets keep cells, no reload unless one cuts a power-on load short
// - programmed bit ignores later writes
// - scan port enabled when bit set
// - code protection on when bit clear
// - program writes blocked when bit clear
// - debug boot when bit clear
// - emulation boot when bit clear
// - pin pair two when bit set
// - watchdog enabled when bit set
// - windowed watchdog when bit clear and watchdog enabled
// - bits nine and five read one
// - prescale and postscale selections decoded
`timescale 1ns/1ps
`include "cfg_loader_map.svh"
module volatile_config_loader
	import cfg_loader_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire logic POR_I,
	output logic FLASH_RD_O,
	output cfg_loader_pkg::word_t FLASH_ADDR_O,
	input wire logic FLASH_VALID_I,
	input wire cfg_loader_pkg::word_t FLASH_DATA_I,
	input wire logic TBL_RD_I,
	input wire logic TBL_WR_I,
	input wire cfg_loader_pkg::word_t TBL_ADDR_I,
	input wire cfg_loader_pkg::word_t TBL_WDATA_I,
	output cfg_loader_pkg::word_t TBL_RDATA_O,
	output logic TBL_HIT_O,
	output logic CORE_RST_O,
	output logic LOAD_DONE_O,
	output logic SCAN_PORT_ENABLE_O,
	output logic CODE_PROTECT_O,
	output logic FLASH_WRITE_PROTECT_O,
	output logic DEBUG_BOOT_O,
	output logic EMULATION_BOOT_O,
	output logic DEBUGGER_PIN_PAIR_SELECT_O,
	output logic WATCHDOG_ENABLE_O,
	output logic WATCHDOG_WINDOWED_O,
	output logic WATCHDOG_PRESCALE_SELECT_O,
	output logic [3:0] WATCHDOG_POSTSCALE_SELECT_O
);
	import cfg_loader_pkg::*;

	// program-once merge: a cell already zero stays zero, ones never clear anything
	function automatic word_t merge_once(input word_t cur, input word_t wr, input word_t mask);
		merge_once = (cur & (wr | ~mask)) | ~mask;
	endfunction

	load_state_t state_q, state_d;
	word_t word1_q, word1_d;
	word_t word2_q, word2_d;
	word_t rdata_q, rdata_d;
	logic hit_q, hit_d;
	logic core_rst_q;
	logic done_q;
	logic rd_q;
	word_t addr_q;
	logic reload_q;

	wire in_cfg_space;
	wire sel_w1;
	wire sel_w2;
	wire loading;
	wire take_w1;
	wire take_w2;

	// only table operations reach configuration space; fetches never see these cells
	assign in_cfg_space = (TBL_ADDR_I >= `CFG_SPACE_LO) && (TBL_ADDR_I <= `CFG_SPACE_HI);
	assign sel_w1 = in_cfg_space && (TBL_ADDR_I == `CFG_REG_WORD1);
	assign sel_w2 = in_cfg_space && (TBL_ADDR_I == `CFG_REG_WORD2);
	assign loading = (state_q != ST_IDLE) && (state_q != ST_DONE);
	assign take_w1 = (state_q == ST_WAIT1) && FLASH_VALID_I;
	assign take_w2 = (state_q == ST_WAIT2) && FLASH_VALID_I;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: state_d = reload_q ? ST_REQ1 : ST_DONE;
			ST_REQ1: state_d = ST_WAIT1;
			ST_WAIT1: state_d = FLASH_VALID_I ? ST_REQ2 : ST_WAIT1;
			ST_REQ2: state_d = ST_WAIT2;
			ST_WAIT2: state_d = FLASH_VALID_I ? ST_DONE : ST_WAIT2;
			ST_DONE: state_d = ST_DONE;
			default: state_d = ST_IDLE;
		endcase
	end

	// word 1 loads and table writes pass through the once-only merge, word 2 ones through a plain AND, so a
	// flash image cannot undo a bit that software already programmed
	always_comb begin
		word1_d = word1_q;
		word2_d = word2_q;
		if (take_w1) begin
			word1_d = merge_once(word1_q, FLASH_DATA_I, `CFG_W1_IMPL_MASK);
		end else if (TBL_WR_I && sel_w1 && !loading) begin
			word1_d = merge_once(word1_q, TBL_WDATA_I, `CFG_W1_IMPL_MASK);
		end
		if (take_w2) begin
			word2_d = word2_q & FLASH_DATA_I;
		end else if (TBL_WR_I && sel_w2 && !loading) begin
			word2_d = word2_q & TBL_WDATA_I;
		end
	end

	always_comb begin
		rdata_d = `CFG_WORD_ONES;
		hit_d = 1'b0;
		if (TBL_RD_I && sel_w1) begin
			// unimplemented positions and the upper byte always read one
			rdata_d = word1_q | `CFG_W1_FORCE_ONES;
			hit_d = 1'b1;
		end else if (TBL_RD_I && sel_w2) begin
			rdata_d = word2_q;
			hit_d = 1'b1;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (POR_I) begin
			word1_q <= `CFG_WORD_ONES;
			word2_q <= `CFG_WORD_ONES;
		end else begin
			word1_q <= word1_d;
			word2_q <= word2_d;
		end
	end

	// power-on arms the load; the state machine sits in idle while POR_I is high,
	// so the request must outlive it. a system reset does not disarm it, so a load
	// cut short by that reset starts again instead of leaving cells half loaded
	always_ff @(posedge MCLK_I) begin
		if (POR_I) begin
			reload_q <= 1'b1;
		end else if (take_w2 && !SYS_RST_I) begin
			reload_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || POR_I) begin
			state_q <= ST_IDLE;
			rd_q <= 1'b0;
			addr_q <= `CFG_FLASH_WORD1;
			core_rst_q <= 1'b1;
			done_q <= 1'b0;
			rdata_q <= `CFG_WORD_ONES;
			hit_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rd_q <= (state_d == ST_REQ1) || (state_d == ST_REQ2);
			addr_q <= (state_d == ST_REQ2) ? `CFG_FLASH_WORD2 : `CFG_FLASH_WORD1;
			core_rst_q <= (state_d != ST_DONE);
			done_q <= (state_d == ST_DONE);
			rdata_q <= rdata_d;
			hit_q <= hit_d;
		end
	end

	// decoded outputs update one clock after the cell; core reset drops in the
	// same edge as done, the extra decode stage is covered by the reset release
	cfg_word_decode u_decode (
		.clk_i(MCLK_I),
		.word1_i(word1_q),
		.scan_port_enable_o(SCAN_PORT_ENABLE_O),
		.code_protect_o(CODE_PROTECT_O),
		.flash_write_protect_o(FLASH_WRITE_PROTECT_O),
		.debug_boot_o(DEBUG_BOOT_O),
		.emulation_boot_o(EMULATION_BOOT_O),
		.debugger_pin_pair_select_o(DEBUGGER_PIN_PAIR_SELECT_O),
		.watchdog_enable_o(WATCHDOG_ENABLE_O),
		.watchdog_windowed_o(WATCHDOG_WINDOWED_O),
		.watchdog_prescale_select_o(WATCHDOG_PRESCALE_SELECT_O),
		.watchdog_postscale_select_o(WATCHDOG_POSTSCALE_SELECT_O)
	);

	assign FLASH_RD_O = rd_q;
	assign FLASH_ADDR_O = addr_q;
	assign TBL_RDATA_O = rdata_q;
	assign TBL_HIT_O = hit_q;
	assign CORE_RST_O = core_rst_q;
	assign LOAD_DONE_O = done_q;
endmodule

// file: inc/cfg_loader_map.svh
// offsets, field positions, reset values and timing counts of the configuration loader
// assumes a 24-bit program word and 24-bit table-access address
`ifndef CFG_LOADER_MAP_SVH
`define CFG_LOADER_MAP_SVH
`define CFG_SPACE_LO 24'h800000
`define CFG_SPACE_HI 24'hFFFFFF
`define CFG_REG_BASE 24'hF80000
`define CFG_REG_WORD1 24'hF80000
`define CFG_REG_WORD2 24'hF80002
`define CFG_FLASH_WORD1 24'h0157FE
`define CFG_FLASH_WORD2 24'h0157FC
`define CFG_WORD_ONES 24'hFFFFFF
`define CFG_W1_IMPL_MASK 24'h007DDF
`define CFG_W1_FORCE_ONES 24'hFF8220
`define CFG_BIT_RSVD 15
`define CFG_BIT_SCAN 14
`define CFG_BIT_CP 13
`define CFG_BIT_WP 12
`define CFG_BIT_DBG 11
`define CFG_BIT_COE 10
`define CFG_BIT_PAIR 8
`define CFG_BIT_WDTEN 7
`define CFG_BIT_WIN 6
`define CFG_BIT_PRE 4
`define CFG_POST_HI 3
`define CFG_POST_LO 0
`define CFG_FETCH_WAIT 2'h1
`endif

// file: inc/cfg_loader_pkg.sv
// types of the configuration loader
// assumes the map header is included wherever offsets are needed
package cfg_loader_pkg;
	typedef logic [23:0] word_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ1 = 3'b001,
		ST_WAIT1 = 3'b010,
		ST_REQ2 = 3'b011,
		ST_WAIT2 = 3'b100,
		ST_DONE = 3'b101
	} load_state_t;
endpackage

// file: hdl/cfg_word_decode.sv
// decodes configuration word 1 into registered control outputs
// assumes the loaded word is already stable while core reset is released
`timescale 1ns/1ps
`include "cfg_loader_map.svh"
module cfg_word_decode
	import cfg_loader_pkg::*;
(
	input wire logic clk_i,
	input wire cfg_loader_pkg::word_t word1_i,
	output logic scan_port_enable_o,
	output logic code_protect_o,
	output logic flash_write_protect_o,
	output logic debug_boot_o,
	output logic emulation_boot_o,
	output logic debugger_pin_pair_select_o,
	output logic watchdog_enable_o,
	output logic watchdog_windowed_o,
	output logic watchdog_prescale_select_o,
	output logic [3:0] watchdog_postscale_select_o
);
	wire win_d;
	// windowed mode only valid while the watchdog is enabled
	assign win_d = ~word1_i[`CFG_BIT_WIN] & word1_i[`CFG_BIT_WDTEN];
	always_ff @(posedge clk_i) begin
		scan_port_enable_o <= word1_i[`CFG_BIT_SCAN];
		code_protect_o <= ~word1_i[`CFG_BIT_CP];
		flash_write_protect_o <= ~word1_i[`CFG_BIT_WP];
		debug_boot_o <= ~word1_i[`CFG_BIT_DBG];
		emulation_boot_o <= ~word1_i[`CFG_BIT_COE];
		debugger_pin_pair_select_o <= word1_i[`CFG_BIT_PAIR];
		watchdog_enable_o <= word1_i[`CFG_BIT_WDTEN];
		watchdog_windowed_o <= win_d;
		watchdog_prescale_select_o <= word1_i[`CFG_BIT_PRE];
		watchdog_postscale_select_o <= word1_i[`CFG_POST_HI:`CFG_POST_LO];
	end
endmodule

// file: tb/flash_cfg_model.sv
// flash program memory model that answers configuration word fetches
// assumes one fetch at a time, answered in the cycle after the request
`timescale 1ns/1ps
module flash_cfg_model
	import cfg_loader_pkg::*;
#(
	parameter word_t WORD2 = 24'hFFFFFF
)
(
	input wire logic clk_i,
	input wire cfg_loader_pkg::word_t w1_i,
	input wire logic rd_i,
	input wire cfg_loader_pkg::word_t addr_i,
	output logic valid_o,
	output cfg_loader_pkg::word_t data_o
);
	word_t pick;
	// off a fetch the data lines toggle, so stale data never looks like an answer
	assign pick = (addr_i == 24'h0157FE) ? w1_i : (addr_i == 24'h0157FC) ? WORD2 : ~data_o;
	initial begin
		valid_o = 1'b0;
		data_o = 24'h000000;
	end
	always @(posedge clk_i) begin
		valid_o <= rd_i;
		data_o <= rd_i ? pick : ~data_o;
	end
endmodule

// file: tb/cfg_loader_chk.sv
// port-level assertions for the volatile configuration loader
// assumes binding to the loader top; every signal is on the system clock
`timescale 1ns/1ps
`include "cfg_loader_map.svh"
module cfg_loader_chk
	import cfg_loader_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire logic POR_I,
	input wire logic FLASH_RD_O,
	input wire cfg_loader_pkg::word_t FLASH_ADDR_O,
	input wire logic TBL_RD_I,
	input wire cfg_loader_pkg::word_t TBL_ADDR_I,
	input wire cfg_loader_pkg::word_t TBL_RDATA_O,
	input wire logic TBL_HIT_O,
	input wire logic CORE_RST_O,
	input wire logic LOAD_DONE_O,
	input wire logic SCAN_PORT_ENABLE_O,
	input wire logic CODE_PROTECT_O,
	input wire logic WATCHDOG_ENABLE_O,
	input wire logic WATCHDOG_WINDOWED_O
);
	wire sel_w1 = TBL_ADDR_I == `CFG_REG_WORD1;
	wire sel_any = sel_w1 || TBL_ADDR_I == `CFG_REG_WORD2;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I || POR_I);
	property p_fetch_pulse; FLASH_RD_O |=> !FLASH_RD_O; endproperty
	a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch strobe too long");
	property p_fetch_addr;
		FLASH_RD_O |-> FLASH_ADDR_O inside {`CFG_FLASH_WORD1, `CFG_FLASH_WORD2};
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("bad fetch address");
	property p_core_hold; !LOAD_DONE_O |-> CORE_RST_O; endproperty
	a_core_hold: assert property (p_core_hold) else $error("core released early");
	property p_read_hit; TBL_RD_I && sel_any |=> TBL_HIT_O; endproperty
	a_read_hit: assert property (p_read_hit) else $error("table read missed");
	property p_read_miss; TBL_RD_I && !sel_any |=> !TBL_HIT_O && TBL_RDATA_O == `CFG_WORD_ONES; endproperty
	a_read_miss: assert property (p_read_miss) else $error("unmapped read hit");
	property p_hit_cause; !TBL_RD_I |=> !TBL_HIT_O; endproperty
	a_hit_cause: assert property (p_hit_cause) else $error("hit without read");
	property p_unimpl_ones;
		TBL_RD_I && sel_w1 |=> TBL_RDATA_O[23:16] == 8'hFF && TBL_RDATA_O[9] && TBL_RDATA_O[5];
	endproperty
	a_unimpl_ones: assert property (p_unimpl_ones) else $error("unused bit low");
	property p_window; WATCHDOG_WINDOWED_O |-> WATCHDOG_ENABLE_O; endproperty
	a_window: assert property (p_window) else $error("window without watchdog");
	property p_por_ones; disable iff (1'b0) POR_I [*4] |-> SCAN_PORT_ENABLE_O && !CODE_PROTECT_O; endproperty
	a_por_ones: assert property (p_por_ones) else $error("cells not ones at power-on");
endmodule
bind volatile_config_loader cfg_loader_chk u_chk (
	.MCLK_I(MCLK_I),
	.SYS_RST_I(SYS_RST_I),
	.POR_I(POR_I),
	.FLASH_RD_O(FLASH_RD_O),
	.FLASH_ADDR_O(FLASH_ADDR_O),
	.TBL_RD_I(TBL_RD_I),
	.TBL_ADDR_I(TBL_ADDR_I),
	.TBL_RDATA_O(TBL_RDATA_O),
	.TBL_HIT_O(TBL_HIT_O),
	.CORE_RST_O(CORE_RST_O),
	.LOAD_DONE_O(LOAD_DONE_O),
	.SCAN_PORT_ENABLE_O(SCAN_PORT_ENABLE_O),
	.CODE_PROTECT_O(CODE_PROTECT_O),
	.WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
	.WATCHDOG_WINDOWED_O(WATCHDOG_WINDOWED_O)
);

// file: tb/test_volatile_config_loader.sv
// testbench: boots the loader from a flash model and checks configuration space
// assumes the flash model answers fetches one cycle after the request
`timescale 1ns/1ps
`include "cfg_loader_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module test_volatile_config_loader;
	import cfg_loader_pkg::*;
	logic MCLK_I = 1'b0, SYS_RST_I = 1'b1, POR_I = 1'b1, TBL_RD_I = 1'b0, TBL_WR_I = 1'b0;
	word_t TBL_ADDR_I = 24'h000000, TBL_WDATA_I = 24'h000000, w1 = 24'hFFFFFF;
	word_t FLASH_ADDR_O, FLASH_DATA_I, TBL_RDATA_O;
	logic FLASH_RD_O, FLASH_VALID_I, TBL_HIT_O, CORE_RST_O, LOAD_DONE_O, SCAN_PORT_ENABLE_O;
	logic CODE_PROTECT_O, FLASH_WRITE_PROTECT_O, DEBUG_BOOT_O, EMULATION_BOOT_O;
	logic DEBUGGER_PIN_PAIR_SELECT_O, WATCHDOG_ENABLE_O, WATCHDOG_WINDOWED_O;
	logic WATCHDOG_PRESCALE_SELECT_O;
	logic [3:0] WATCHDOG_POSTSCALE_SELECT_O;
	// upper byte ones and reserved bit 15 kept at one by the programming side
	word_t wv[2] = '{24'hFF8A4B, 24'hFFF594};
	word_t rv[2] = '{24'hFF8A6B, 24'hFFF7B4};
	logic [12:0] dv[2] = '{13'h0D0B, 13'h12F4};
	// word 2 image with ones in its upper byte and a mix of programmed bits below
	localparam word_t w2_image = 24'hFFC7A5;
	logic [12:0] dec;
	int n_errors = 0, n_compared = 0, n_fetch = 0, cyc = 0;
	assign dec = {SCAN_PORT_ENABLE_O, CODE_PROTECT_O, FLASH_WRITE_PROTECT_O, DEBUG_BOOT_O,
		EMULATION_BOOT_O, DEBUGGER_PIN_PAIR_SELECT_O, WATCHDOG_ENABLE_O, WATCHDOG_WINDOWED_O,
		WATCHDOG_PRESCALE_SELECT_O, WATCHDOG_POSTSCALE_SELECT_O};
	volatile_config_loader uut (
		.MCLK_I(MCLK_I),
		.SYS_RST_I(SYS_RST_I),
		.POR_I(POR_I),
		.FLASH_RD_O(FLASH_RD_O),
		.FLASH_ADDR_O(FLASH_ADDR_O),
		.FLASH_VALID_I(FLASH_VALID_I),
		.FLASH_DATA_I(FLASH_DATA_I),
		.TBL_RD_I(TBL_RD_I),
		.TBL_WR_I(TBL_WR_I),
		.TBL_ADDR_I(TBL_ADDR_I),
		.TBL_WDATA_I(TBL_WDATA_I),
		.TBL_RDATA_O(TBL_RDATA_O),
		.TBL_HIT_O(TBL_HIT_O),
		.CORE_RST_O(CORE_RST_O),
		.LOAD_DONE_O(LOAD_DONE_O),
		.SCAN_PORT_ENABLE_O(SCAN_PORT_ENABLE_O),
		.CODE_PROTECT_O(CODE_PROTECT_O),
		.FLASH_WRITE_PROTECT_O(FLASH_WRITE_PROTECT_O),
		.DEBUG_BOOT_O(DEBUG_BOOT_O),
		.EMULATION_BOOT_O(EMULATION_BOOT_O),
		.DEBUGGER_PIN_PAIR_SELECT_O(DEBUGGER_PIN_PAIR_SELECT_O),
		.WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
		.WATCHDOG_WINDOWED_O(WATCHDOG_WINDOWED_O),
		.WATCHDOG_PRESCALE_SELECT_O(WATCHDOG_PRESCALE_SELECT_O),
		.WATCHDOG_POSTSCALE_SELECT_O(WATCHDOG_POSTSCALE_SELECT_O)
	);
	flash_cfg_model #(.WORD2(w2_image)) flash (.clk_i(MCLK_I), .w1_i(w1), .rd_i(FLASH_RD_O),
		.addr_i(FLASH_ADDR_O), .valid_o(FLASH_VALID_I), .data_o(FLASH_DATA_I));
	always #20 MCLK_I = ~MCLK_I;
	always @(posedge MCLK_I) begin
		n_fetch += (FLASH_RD_O === 1'b1);
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			final_report;
		end
	end
	task final_report;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task boot(input logic p);
		@(negedge MCLK_I);
		SYS_RST_I = 1'b1;
		POR_I = p;
		repeat (4) @(negedge MCLK_I);
		SYS_RST_I = 1'b0;
		POR_I = 1'b0;
		for (int i = 0; i < 50 && LOAD_DONE_O !== 1'b1; i++) @(negedge MCLK_I);
	endtask
	// answer stands one cycle, so it is checked at the negedge right after the take
	task access(input logic w, input word_t a, input word_t d);
		@(negedge MCLK_I);
		TBL_RD_I = ~w;
		TBL_WR_I = w;
		TBL_ADDR_I = a;
		TBL_WDATA_I = d;
		@(negedge MCLK_I);
		TBL_RD_I = 1'b0;
		TBL_WR_I = 1'b0;
	endtask
	initial begin
		for (int k = 0; k < 2; k++) begin
			w1 = wv[k];
			n_fetch = 0;
			boot(1'b1);
			`CHK("fetch count", 2, n_fetch)
			`CHK("core reset", 1'b0, CORE_RST_O)
			`CHK("load done", 1'b1, LOAD_DONE_O)
			access(1'b0, `CFG_REG_WORD1, 24'h000000);
			`CHK("word1 read", rv[k], TBL_RDATA_O)
			`CHK("word1 hit", 1'b1, TBL_HIT_O)
			`CHK("decode protect", dv[k][12:10], dec[12:10])
			`CHK("decode boot", dv[k][9:7], dec[9:7])
			`CHK("decode watchdog", dv[k][6:5], dec[6:5])
			`CHK("decode scale", dv[k][4:0], dec[4:0])
			access(1'b0, `CFG_REG_WORD2, 24'h000000);
			`CHK("word2 read", w2_image, TBL_RDATA_O)
			`CHK("word2 hit", 1'b1, TBL_HIT_O)
		end
		access(1'b1, `CFG_REG_WORD1, `CFG_WORD_ONES);
		access(1'b0, `CFG_REG_WORD1, 24'h000000);
		`CHK("write once", 24'hFFF7B4, TBL_RDATA_O)
		n_fetch = 0;
		boot(1'b0);
		`CHK("no reload", 0, n_fetch)
		access(1'b0, `CFG_REG_WORD1, 24'h000000);
		`CHK("kept word", 24'hFFF7B4, TBL_RDATA_O)
		access(1'b0, 24'h800004, 24'h000000);
		`CHK("unmapped hit", 1'b0, TBL_HIT_O)
		`CHK("unmapped data", `CFG_WORD_ONES, TBL_RDATA_O)
		final_report;
	end
endmodule
